// >>> bench/port6_board.sv
// board model: resolves the port 6 pad levels
// assumes the block's pad outputs and a bench drive
`timescale 1ns/1ps
`default_nettype none
module port6_board (
    // pads and board drivers
    input wire logic clock,
    input wire logic [7:0] pad_out, pad_oe, pad_pullup, ext_drive, ext_en,
    output logic [7:0] pad_in
);
    // ================
    // released lines toggle unless pulled up
    logic flip = 1'h0;
    always @(posedge clock) flip <= ~flip;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drive)
        | (~pad_oe & ~ext_en & (pad_pullup | {8{flip}}));
endmodule : port6_board
`default_nettype wire

// >>> bench/port6_chk.sv
// assertions on the port 6 pin-function block
// bound to its top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module port6_chk (
    // watched ports
    input wire logic clock, sys_rst, serial1_pin_select, serial_mode_bit2,
    input wire logic serial_mode_bit1, serial_mode_bit0, clock_direction_sel,
    input wire logic open_drain_select, irq_two_enable, timer_out_enable,
    input wire logic timer_wave_pin, serial1_clock_out, serial1_transmit_out,
    input wire logic protect_bit_one, mode1_we, irq_two_in,
    input wire logic count_source_protect_on,
    input wire logic [7:0] pad_in, pad_out, pad_oe, port6_direction,
    input wire logic [7:0] processor_mode_reg1
);
    // ================
    // pin routing and processor mode register 1
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic [2:0] md = {serial_mode_bit2, serial_mode_bit1,
        serial_mode_bit0};
    wire logic tx = serial1_pin_select && md inside {3'h1, 3'h4, 3'h5, 3'h6};
    wire logic ck = serial1_pin_select && md == 3'h1 && !clock_direction_sel;
    property p_rst; $past(sys_rst) |-> pad_oe == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("oe after reset");
    property p_low;
        !$past(sys_rst) |-> pad_oe[4:1] == $past(port6_direction[4:1]);
    endproperty
    a_low: assert property (p_low) else $error("pins 1-4 oe");
    property p_ck; ck |=> pad_oe[5] && pad_out[5] == $past(serial1_clock_out);
    endproperty
    a_ck: assert property (p_ck) else $error("clock out");
    property p_tx; tx && !open_drain_select |=> pad_oe[6]
        && pad_out[6] == $past(serial1_transmit_out); endproperty
    a_tx: assert property (p_tx) else $error("tx push-pull");
    property p_od; tx && open_drain_select |=>
        pad_oe[6] != $past(serial1_transmit_out); endproperty
    a_od: assert property (p_od) else $error("tx open-drain");
    property p_tm; timer_out_enable |=> pad_oe[0]
        && pad_out[0] == $past(timer_wave_pin); endproperty
    a_tm: assert property (p_tm) else $error("timer out");
    property p_irq; !port6_direction[6] && irq_two_enable |=>
        irq_two_in == $past(pad_in[6]); endproperty
    a_irq: assert property (p_irq) else $error("irq route");
    property p_pr; mode1_we && !protect_bit_one && !count_source_protect_on
        |=> $stable(processor_mode_reg1); endproperty
    a_pr: assert property (p_pr) else $error("mode1 guarded");
    property p_st; processor_mode_reg1[2] |=> processor_mode_reg1[2];
    endproperty
    a_st: assert property (p_st) else $error("sticky bit");
    c_tm: cover property (timer_out_enable);
    c_od: cover property (tx && open_drain_select);
    c_pr: cover property (mode1_we && !protect_bit_one);
endmodule : port6_chk
bind port6_pin_function_select port6_chk chk (.*);
`default_nettype wire

// >>> bench/port6_pin_function_select_tb.sv
// testbench for the port 6 pin-function block
// assumes the board model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module port6_pin_function_select_tb;
    // ================
    // stimulus and observation
    logic clock = 1'h0, sys_rst = 1'h1, direction_we = 1'h0, pullup_we = 1'h0;
    logic pullup_group_low = 1'h0, pullup_group_high = 1'h0, mode1_we = 1'h0;
    logic serial1_pin_select = 1'h0, clock_direction_sel = 1'h0;
    logic open_drain_select = 1'h0, irq_two_enable = 1'h0;
    logic irq_three_enable = 1'h0, timer_out_enable = 1'h0;
    logic timer_wave_pin = 1'h0, serial1_clock_out = 1'h0;
    logic serial1_transmit_out = 1'h0, protect_bit_one = 1'h0;
    logic count_source_protect_on = 1'h0, serial_mode_bit2 = 1'h0;
    logic serial_mode_bit1 = 1'h0, serial_mode_bit0 = 1'h0;
    logic [7:0] direction_wdata = 8'h00, port_out_data = 8'ha5;
    logic [7:0] mode1_wdata = 8'h00, xd = 8'h00, xe = 8'h00;
    logic [2:0] modes [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h2};
    wire logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, port6_direction;
    wire logic [7:0] port_in_data, processor_mode_reg1;
    wire logic serial1_clock_pin, serial1_receive_pin, irq_two_in;
    wire logic irq_three_in, single_chip_mode;
    int fail_count = 0;
    int compares = 0;
    always #20 clock = ~clock;
    port6_pin_function_select uut (.*);
    port6_board brd (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_drive(xd), .ext_en(xe), .pad_in(pad_in));
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wt
    task automatic wd(input logic [7:0] d);
        @(posedge clock);
        direction_we <= 1'h1;
        direction_wdata <= d;
        @(posedge clock);
        direction_we <= 1'h0;
        wt(2);
    endtask : wd
    task automatic pu(input logic l, h);
        @(posedge clock);
        {pullup_we, pullup_group_low, pullup_group_high} <= {1'h1, l, h};
        @(posedge clock);
        pullup_we <= 1'h0;
        wt(3);
    endtask : pu
    task automatic wm(input logic p, input logic [7:0] d);
        @(posedge clock);
        {protect_bit_one, mode1_we, mode1_wdata} <= {p, 1'h1, d};
        @(posedge clock);
        mode1_we <= 1'h0;
        wt(1);
    endtask : wm
    task automatic end_of_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'h0;
        wt(2);
        chk("oe", 8'h00, pad_oe);
        chk("single", 8'h01, {7'h0, single_chip_mode});
        wd(8'h1e);
        chk("direction", 8'h1e, port6_direction);
        chk("oe", 8'h1e, pad_oe);
        pu(1'h1, 1'h0);
        chk("pullup", 8'h01, pad_pullup);
        pu(1'h0, 1'h1);
        chk("pullup", 8'he0, pad_pullup);
        @(posedge clock);
        {timer_out_enable, timer_wave_pin} <= 2'h3;
        wt(2);
        chk("in", 8'h05, port_in_data & 8'h05);
        @(posedge clock);
        {timer_out_enable, serial1_pin_select, serial_mode_bit0} <= 3'h3;
        {serial1_clock_out, serial1_transmit_out} <= 2'h1;
        wt(2);
        chk("oe", 8'h7e, pad_oe);
        chk("out", 8'hc5, pad_out);
        @(posedge clock);
        {clock_direction_sel, xe, xd} <= {1'h1, 8'h20, 8'h20};
        wt(3);
        chk("clock in", 8'h01, {7'h0, serial1_clock_pin});
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            {serial_mode_bit2, serial_mode_bit1, serial_mode_bit0} <= modes[i/2];
            open_drain_select <= i[0];
            wt(2);
            chk("tx oe", {7'h0, i < 8 && !i[0]}, {7'h0, pad_oe[6]});
        end
        wd(8'h00);
        @(posedge clock);
        {serial_mode_bit2, serial_mode_bit1, serial_mode_bit0} <= 3'h0;
        {irq_two_enable, irq_three_enable, xe} <= {2'h3, 8'hc0};
        for (int v = 0; v < 2; v++) begin
            @(posedge clock);
            xd <= {v[0], v[0], 6'h00};
            wt(2);
            chk("routes", {5'h0, {3{v[0]}}}, {5'h0, irq_two_in, irq_three_in,
                serial1_receive_pin});
        end
        $display("test pins done");
        wm(1'h0, 8'hff);
        chk("mode1", 8'h00, processor_mode_reg1);
        wm(1'h1, 8'h04);
        wm(1'h1, 8'h00);
        chk("mode1", 8'h04, processor_mode_reg1);
        @(posedge clock);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clock);
        {sys_rst, count_source_protect_on} <= 2'h1;
        wt(2);
        chk("mode1", 8'h04, processor_mode_reg1);
        $display("test mode done");
        end_of_test();
    end
endmodule : port6_pin_function_select_tb
`default_nettype wire

// >>> verilog/port6_pin_function_select.sv
// pin-function selection for an 8-bit general-purpose port
// assumes control bits arrive as synchronous levels from register logic
`timescale 1ns/1ps
`default_nettype none

// Operation
// - pull-ups on inputs 0..3 enabled only when low group bit is 1
// - pull-ups on inputs 4..7 enabled only when high group bit is 1
// - pin 5 is serial clock input when input, pin select 1, external clock
// - pin 5 drives serial clock in mode 001b with internal clock
// - pin 6 push-pull transmit in transmit modes with open-drain select 0
// - pin 6 open-drain transmit in the same modes with open-drain select 1
// - only single-chip mode: every pin is port or peripheral pin
// - mode register 1 writes ignored unless protect bit one is 1
// - sticky mode bit is set-only by program writes
// - sticky mode bit forced to 1 when count source protect is on
// - pins stay inputs after reset until direction bits are written or the timer, clock or transmit output drives pin 0, 5 or 6
module port6_pin_function_select #(
    // pins in the port
    parameter int PORT_WIDTH = 8,
    // pins that share one pull-up control bit
    parameter int PULLUP_GROUP = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // direction register write
    input wire logic direction_we,
    input wire logic [PORT_WIDTH-1:0] direction_wdata,
    // port data register value
    input wire logic [PORT_WIDTH-1:0] port_out_data,
    // pull-up control bits
    input wire logic pullup_we,
    input wire logic pullup_group_low,
    input wire logic pullup_group_high,
    // serial channel 1 settings
    input wire logic serial1_pin_select,
    input wire logic serial_mode_bit2,
    input wire logic serial_mode_bit1,
    input wire logic serial_mode_bit0,
    input wire logic clock_direction_sel,
    input wire logic open_drain_select,
    // external interrupt and timer output enables
    input wire logic irq_two_enable,
    input wire logic irq_three_enable,
    input wire logic timer_out_enable,
    // peripheral output levels
    input wire logic timer_wave_pin,
    input wire logic serial1_clock_out,
    input wire logic serial1_transmit_out,
    // processor mode register 1 write
    input wire logic protect_bit_one,
    input wire logic mode1_we,
    input wire logic [7:0] mode1_wdata,
    input wire logic count_source_protect_on,
    // pad side
    input wire logic [PORT_WIDTH-1:0] pad_in,
    output logic [PORT_WIDTH-1:0] pad_out,
    output logic [PORT_WIDTH-1:0] pad_oe,
    output logic [PORT_WIDTH-1:0] pad_pullup,
    // peripheral inputs
    output logic serial1_clock_pin,
    output logic serial1_receive_pin,
    output logic irq_two_in,
    output logic irq_three_in,
    // status
    output logic [PORT_WIDTH-1:0] port6_direction,
    output logic [PORT_WIDTH-1:0] port_in_data,
    output logic [7:0] processor_mode_reg1,
    output logic single_chip_mode
);
    // ==========================================================
    // parameter check
    // the pin functions sit at fixed positions 0 to 7,
    // split into a low and a high pull-up group
    if (PORT_WIDTH != 8) begin : g_width_check
        $error("port width must be 8");
    end
    if (2 * PULLUP_GROUP != PORT_WIDTH) begin : g_group_check
        $error("two pull-up groups must cover the port");
    end

    // ==========================================================
    // helper functions
    // the transmit pin is used by the clock-synchronous mode
    // and by the three asynchronous frame lengths
    function automatic logic is_transmit_mode(input logic [2:0] code);
        logic hit;
        case (code)
            port6_pkg::SMD_CLOCK_SYNC: hit = 1'b1;
            port6_pkg::SMD_UART7: hit = 1'b1;
            port6_pkg::SMD_UART8: hit = 1'b1;
            port6_pkg::SMD_UART9: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : is_transmit_mode

    // pull-up request of one group: only pins that are not driven
    function automatic logic [PULLUP_GROUP-1:0] group_pullup(
        input logic enable,
        input logic [PULLUP_GROUP-1:0] oe
    );
        return {PULLUP_GROUP{enable}} & ~oe;
    endfunction : group_pullup

    // level handed to a peripheral input: the pad when routed, else 0
    function automatic logic routed_level(
        input logic route,
        input logic level
    );
        return route & level;
    endfunction : routed_level

    // ==========================================================
    // stored control
    logic [PORT_WIDTH-1:0] direction;
    logic pu_low;
    logic pu_high;
    logic [7:0] mode1;

    // direction bits: every pin starts as an input
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            direction <= port6_pkg::DIRECTION_RESET;
        end else if (direction_we) begin
            direction <= direction_wdata;
        end
    end

    // both pull-up group bits load together
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pu_low <= port6_pkg::PULLUP_RESET;
            pu_high <= port6_pkg::PULLUP_RESET;
        end else if (pullup_we) begin
            pu_low <= pullup_group_low;
            pu_high <= pullup_group_high;
        end
    end

    // ==========================================================
    // processor mode register 1
    // a write without the protect bit is dropped silently
    wire mode1_write_ok = mode1_we && protect_bit_one;
    wire [7:0] mode1_written = mode1_write_ok ? mode1_wdata : mode1;
    // sticky bit: a program may set it, only reset clears it
    wire sticky_by_write = mode1_write_ok
        && mode1_wdata[port6_pkg::STICKY_BIT];
    // count source protect forces the bit and wins over a write of 0
    wire sticky_next = mode1[port6_pkg::STICKY_BIT]
        || sticky_by_write
        || count_source_protect_on;
    logic [7:0] next_mode1;

    always_comb begin
        next_mode1 = mode1_written;
        next_mode1[port6_pkg::STICKY_BIT] = sticky_next;
    end

    // loads every cycle; cycles without a write hold the old value except a sticky bit forced by count source protect
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode1 <= port6_pkg::MODE1_RESET;
        end else begin
            mode1 <= next_mode1;
        end
    end

    // ==========================================================
    // function decode
    // serial mode field assembled from its three bits
    wire [2:0] smd = {serial_mode_bit2, serial_mode_bit1, serial_mode_bit0};
    wire mode_clock_sync = (smd == port6_pkg::SMD_CLOCK_SYNC);
    wire mode_transmit = is_transmit_mode(smd);
    // pin 0: timer output overrides the direction bit
    wire timer_drive = timer_out_enable;
    // pin 5: internal clock out, or external clock in while an input
    wire clock_drive = serial1_pin_select && mode_clock_sync
        && !clock_direction_sel;
    wire clock_input = !direction[port6_pkg::PIN_CLOCK]
        && serial1_pin_select && clock_direction_sel;
    // pin 6: transmit data, push-pull or open drain
    wire transmit_drive = serial1_pin_select && mode_transmit;
    wire transmit_od = transmit_drive && open_drain_select;
    // pins 6 and 7: interrupt and receive routes need an input pin
    wire irq2_route = !direction[port6_pkg::PIN_TRANSMIT] && irq_two_enable;
    wire irq3_route = !direction[port6_pkg::PIN_RECEIVE] && irq_three_enable;
    wire rx_route = !direction[port6_pkg::PIN_RECEIVE] && serial1_pin_select;

    // ==========================================================
    // pad output selection
    // pins 1 to 4 and 7 have no output function and follow the bit
    wire [PORT_WIDTH-1:0] port_oe = direction;
    // pin 0
    wire out_timer_pin = timer_drive
        ? timer_wave_pin : port_out_data[port6_pkg::PIN_TIMER];
    wire oe_timer_pin = timer_drive || direction[port6_pkg::PIN_TIMER];
    // pin 5
    wire out_clock_pin = clock_drive
        ? serial1_clock_out : port_out_data[port6_pkg::PIN_CLOCK];
    wire oe_clock_pin = clock_drive || direction[port6_pkg::PIN_CLOCK];
    // pin 6: open drain drives only the low level
    wire out_transmit_pin = transmit_drive
        ? serial1_transmit_out : port_out_data[port6_pkg::PIN_TRANSMIT];
    wire oe_transmit_push = transmit_drive && !transmit_od;
    wire oe_transmit_od = transmit_od && !serial1_transmit_out;
    wire oe_transmit_pin = transmit_drive
        ? (oe_transmit_push || oe_transmit_od)
        : direction[port6_pkg::PIN_TRANSMIT];

    logic [PORT_WIDTH-1:0] next_out;
    logic [PORT_WIDTH-1:0] next_oe;
    wire [PORT_WIDTH-1:0] next_pullup;

    always_comb begin
        next_out = port_out_data;
        next_out[port6_pkg::PIN_TIMER] = out_timer_pin;
        next_out[port6_pkg::PIN_CLOCK] = out_clock_pin;
        next_out[port6_pkg::PIN_TRANSMIT] = out_transmit_pin;
    end

    always_comb begin
        next_oe = port_oe;
        next_oe[port6_pkg::PIN_TIMER] = oe_timer_pin;
        next_oe[port6_pkg::PIN_CLOCK] = oe_clock_pin;
        next_oe[port6_pkg::PIN_TRANSMIT] = oe_transmit_pin;
    end

    // pull-ups only on pins that are not driven
    assign next_pullup[PULLUP_GROUP-1:0] =
        group_pullup(pu_low, next_oe[PULLUP_GROUP-1:0]);
    assign next_pullup[PORT_WIDTH-1:PULLUP_GROUP] =
        group_pullup(pu_high, next_oe[PORT_WIDTH-1:PULLUP_GROUP]);

    // ==========================================================
    // registered pad outputs
    // pads follow a control change one cycle later
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pad_out <= port6_pkg::PAD_RESET;
            pad_oe <= port6_pkg::PAD_RESET;
            pad_pullup <= port6_pkg::PAD_RESET;
        end else begin
            pad_out <= next_out;
            pad_oe <= next_oe;
            pad_pullup <= next_pullup;
        end
    end

    // ==========================================================
    // registered peripheral inputs
    // serial clock and receive data
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial1_clock_pin <= port6_pkg::PIN_RESET;
            serial1_receive_pin <= port6_pkg::PIN_RESET;
        end else begin
            serial1_clock_pin <= routed_level(clock_input,
                pad_in[port6_pkg::PIN_CLOCK]);
            serial1_receive_pin <= routed_level(rx_route,
                pad_in[port6_pkg::PIN_RECEIVE]);
        end
    end

    // external interrupt inputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_two_in <= port6_pkg::PIN_RESET;
            irq_three_in <= port6_pkg::PIN_RESET;
        end else begin
            irq_two_in <= routed_level(irq2_route,
                pad_in[port6_pkg::PIN_TRANSMIT]);
            irq_three_in <= routed_level(irq3_route,
                pad_in[port6_pkg::PIN_RECEIVE]);
        end
    end

    // ==========================================================
    // status
    // pad levels are sampled every cycle, whatever the direction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port_in_data <= port6_pkg::PAD_RESET;
        end else begin
            port_in_data <= pad_in;
        end
    end

    // only single-chip mode exists; the flag rises once reset is released
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            single_chip_mode <= port6_pkg::PIN_RESET;
        end else begin
            single_chip_mode <= 1'b1;
        end
    end

    assign port6_direction = direction;
    assign processor_mode_reg1 = mode1;
endmodule : port6_pin_function_select
`default_nettype wire

// >>> verilog/port6_pkg.sv
// constants for the port 6 pin-function selection block
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
package port6_pkg;
    // ==========================================================
    // serial mode field encodings
    localparam logic [2:0] SMD_CLOCK_SYNC = 3'h1;
    localparam logic [2:0] SMD_UART7 = 3'h4;
    localparam logic [2:0] SMD_UART8 = 3'h5;
    localparam logic [2:0] SMD_UART9 = 3'h6;
    // ==========================================================
    // bit positions and reset values
    localparam int PIN_TIMER = 0;
    localparam int PIN_CLOCK = 5;
    localparam int PIN_TRANSMIT = 6;
    localparam int PIN_RECEIVE = 7;
    localparam int STICKY_BIT = 2;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] MODE1_RESET = 8'h00;
    localparam logic PULLUP_RESET = 1'h0;
    localparam logic [7:0] PAD_RESET = 8'h00;
    localparam logic PIN_RESET = 1'h0;
endpackage : port6_pkg
`default_nettype wire
